// ==== verilog/hbp_pkg.sv ====
package hbp_pkg;
	// register byte offsets on the axi4-lite slave
	localparam logic [7:0] OFF_DB_CTRL = 8'h00;
	localparam logic [7:0] OFF_SD_CTRL = 8'h04;
	localparam logic [7:0] OFF_INT_STAT = 8'h08;
	localparam logic [7:0] OFF_INT_MASK = 8'h0c;
	localparam logic [7:0] OFF_MODE = 8'h10;
	localparam logic [7:0] OFF_SRC_STAT = 8'h14;
	// field positions
	localparam int DB_RESTART_BIT = 7;
	localparam int DB_COUNT_LSB = 0;
	localparam int DB_COUNT_W = 7;
	localparam int SD_FLAG_BIT = 7;
	localparam int SD_SEL_LSB = 4;
	localparam int SD_AC_LSB = 2;
	localparam int SD_BD_LSB = 0;
	localparam int IRQ_SHUTDOWN_BIT = 0;
	localparam int IRQ_RESUME_BIT = 1;
	// values after reset
	localparam logic [7:0] DB_CTRL_RST = 8'h00;
	localparam logic [6:0] SD_CFG_RST = 7'h00;
	localparam logic [1:0] INT_RST = 2'h0;
	localparam logic [1:0] MODE_RST = 2'h1;
	// one dead-band unit is one instruction cycle, which here equals one clock period of 4 ns
	localparam int CLK_PERIOD_NS = 4;
	localparam int TCY_NS = 4;
	localparam int DB_UNIT_CYCLES = (TCY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [7:0] DB_UNIT_LAST = 8'(DB_UNIT_CYCLES - 1);
	// axi responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// output modes
	typedef enum logic [1:0] {
		HBP_MODE_SINGLE = 2'h0,
		HBP_MODE_HALF = 2'h1,
		HBP_MODE_FWD = 2'h2,
		HBP_MODE_REV = 2'h3
	} hbp_mode_t;
	// pin pair state while shut down; code 3 also floats
	typedef enum logic [1:0] {
		HBP_SD_LOW = 2'h0,
		HBP_SD_HIGH = 2'h1,
		HBP_SD_FLOAT = 2'h2,
		HBP_SD_FLOAT2 = 2'h3
	} hbp_sdstate_t;
endpackage

// ==== verilog/hbp_top.sv ====
// The register offsets and register access over AXI4-Lite were decided locally.
`timescale 1ns/100ps
// Overview of operation
// - half-bridge mode drives pwm on pin a and its complement on pin b
// - seven-bit dead-band count sits in bits 6-0 of the dead-band register
// - dead-band delays only inactive-to-active edges, never the falling ones
// - one count unit equals one instruction cycle, which here is one clock period
// - count longer than active time keeps that output inactive all cycle
// - auto-shutdown covers the active pins in every output mode
// - three-bit select in bits 6:4 picks comparators and low fault input
// - with no source selected the shutdown state is never entered
// - shutdown forces pins at once, not waiting for a period boundary
// - two-bit fields set pairs a/c and b/d high, low or floating
// - hardware sets shutdown flag bit 7; outputs held while it is set
// - restart enable clears flag when cause goes; otherwise firmware clears
// - writes to the shutdown flag are ignored while a cause is active
// - flag set at period start holds shutdown states that whole period
// - after flag clears, normal output resumes only at next period start
module hbp_top #(
	parameter int ADDR_W = 8
) (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// axi4-lite write address and data
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// axi4-lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// from the duty and period generator, same clock
	input wire logic pwm_in,
	input wire logic period_start,
	// shutdown sources from pins and comparators, asynchronous
	input wire logic cmp1_in,
	input wire logic cmp2_in,
	input wire logic fault_in_n,
	// bridge pins
	output logic bridge_out_a,
	output logic bridge_oe_a,
	output logic bridge_out_b,
	output logic bridge_oe_b,
	output logic bridge_out_c,
	output logic bridge_oe_c,
	output logic bridge_out_d,
	output logic bridge_oe_d,
	// interrupt
	output logic irq
);
	import hbp_pkg::*;

	logic [2:0] src_meta_reg, src_sync_reg, shutdown_source_sel;
	logic [7:0] db_ctrl_reg, wbyte_reg, unit_cnt_reg;
	logic [6:0] sd_cfg_reg, deadband_count;
	logic shutdown_active_flag_reg, forced_reg, wstrb0_reg, aw_held_reg, w_held_reg;
	logic [1:0] int_stat_reg, int_mask_reg, rresp_next, req, req_d_reg, act_reg;
	hbp_mode_t mode_reg;
	logic [ADDR_W-1:0] awaddr_reg;
	logic [31:0] rdata_next;
	logic unit_tick, auto_restart_en, sd_cond, wr_fire, rd_fire, shutdown_event, resume_event;
	hbp_sdstate_t shutdown_state_ac, shutdown_state_bd;
	logic [6:0] dly_cnt_reg [2];
	logic [3:0] used, out_next, oe_next;

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// two flops on each asynchronous source; order {fault low, cmp2, cmp1}
	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++) begin : g_sync
			always_ff @(posedge aclk) begin
				if (!aresetn) begin
					src_meta_reg[gi] <= 1'b0;
					src_sync_reg[gi] <= 1'b0;
				end else begin
					src_meta_reg[gi] <= (gi == 2) ? !fault_in_n : (gi == 1 ? cmp2_in : cmp1_in);
					src_sync_reg[gi] <= src_meta_reg[gi];
				end
			end
		end
	endgenerate

	// field views of the control registers
	assign deadband_count = db_ctrl_reg[DB_COUNT_LSB +: DB_COUNT_W];
	assign auto_restart_en = db_ctrl_reg[DB_RESTART_BIT];
	assign shutdown_source_sel = sd_cfg_reg[SD_SEL_LSB +: 3];
	assign shutdown_state_ac = hbp_sdstate_t'(sd_cfg_reg[SD_AC_LSB +: 2]);
	assign shutdown_state_bd = hbp_sdstate_t'(sd_cfg_reg[SD_BD_LSB +: 2]);
	// any selected source is enough; an empty selection can never trip
	assign sd_cond = |(shutdown_source_sel & src_sync_reg);
	assign wr_fire = aw_held_reg && w_held_reg && !s_axi_bvalid;
	assign rd_fire = s_axi_arvalid && s_axi_arready;
	assign shutdown_event = sd_cond && !shutdown_active_flag_reg;
	assign resume_event = forced_reg && period_start && !shutdown_active_flag_reg && !sd_cond;

	// write channel: address and data are taken in either order, response after both
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			aw_held_reg <= 1'b0;
			w_held_reg <= 1'b0;
			awaddr_reg <= '0;
			wbyte_reg <= 8'h00;
			wstrb0_reg <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				awaddr_reg <= s_axi_awaddr;
				aw_held_reg <= 1'b1;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wbyte_reg <= s_axi_wdata[7:0];
				wstrb0_reg <= s_axi_wstrb[0];
				w_held_reg <= 1'b1;
				s_axi_wready <= 1'b0;
			end
			if (wr_fire) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (awaddr_reg == OFF_DB_CTRL || awaddr_reg == OFF_SD_CTRL ||
					awaddr_reg == OFF_INT_STAT || awaddr_reg == OFF_INT_MASK ||
					awaddr_reg == OFF_MODE || awaddr_reg == OFF_SRC_STAT) ? RESP_OKAY : RESP_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				aw_held_reg <= 1'b0;
				w_held_reg <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end

	// plain configuration registers; only byte lane 0 carries data
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			db_ctrl_reg <= DB_CTRL_RST;
			sd_cfg_reg <= SD_CFG_RST;
			int_mask_reg <= INT_RST;
			mode_reg <= hbp_mode_t'(MODE_RST);
		end else if (wr_fire && wstrb0_reg) begin
			if (awaddr_reg == OFF_DB_CTRL) begin
				db_ctrl_reg <= wbyte_reg;
			end else if (awaddr_reg == OFF_SD_CTRL) begin
				sd_cfg_reg <= wbyte_reg[6:0];
			end else if (awaddr_reg == OFF_INT_MASK) begin
				int_mask_reg <= wbyte_reg[1:0];
			end else if (awaddr_reg == OFF_MODE) begin
				mode_reg <= hbp_mode_t'(wbyte_reg[1:0]);
			end
		end
	end

	// shutdown flag: hardware set beats every clear, writes ignored while a cause stands
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			shutdown_active_flag_reg <= 1'b0;
		end else if (sd_cond) begin
			shutdown_active_flag_reg <= 1'b1;
		end else if (auto_restart_en) begin
			shutdown_active_flag_reg <= 1'b0;
		end else if (wr_fire && wstrb0_reg && awaddr_reg == OFF_SD_CTRL && !wbyte_reg[SD_FLAG_BIT]) begin
			shutdown_active_flag_reg <= 1'b0;
		end
	end

	// pins stay forced until a period starts with the flag clear
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			forced_reg <= 1'b0;
		end else if (sd_cond || shutdown_active_flag_reg) begin
			forced_reg <= 1'b1;
		end else if (period_start) begin
			forced_reg <= 1'b0;
		end
	end

	// sticky event bits; a new event outranks the clear by read
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			int_stat_reg <= INT_RST;
			irq <= 1'b0;
		end else begin
			int_stat_reg[IRQ_SHUTDOWN_BIT] <= shutdown_event ||
				(int_stat_reg[IRQ_SHUTDOWN_BIT] && !(rd_fire && s_axi_araddr == OFF_INT_STAT));
			int_stat_reg[IRQ_RESUME_BIT] <= resume_event ||
				(int_stat_reg[IRQ_RESUME_BIT] && !(rd_fire && s_axi_araddr == OFF_INT_STAT));
			irq <= |(int_stat_reg & int_mask_reg);
		end
	end

	// read data selection
	always_comb begin
		rdata_next = 32'h0000_0000;
		rresp_next = RESP_OKAY;
		if (s_axi_araddr == OFF_DB_CTRL) begin
			rdata_next[7:0] = db_ctrl_reg;
		end else if (s_axi_araddr == OFF_SD_CTRL) begin
			rdata_next[7:0] = {shutdown_active_flag_reg, sd_cfg_reg};
		end else if (s_axi_araddr == OFF_INT_STAT) begin
			rdata_next[1:0] = int_stat_reg;
		end else if (s_axi_araddr == OFF_INT_MASK) begin
			rdata_next[1:0] = int_mask_reg;
		end else if (s_axi_araddr == OFF_MODE) begin
			rdata_next[1:0] = mode_reg;
		end else if (s_axi_araddr == OFF_SRC_STAT) begin
			rdata_next[4:0] = {forced_reg, sd_cond, src_sync_reg};
		end else begin
			rresp_next = RESP_SLVERR;
		end
	end

	// read channel: answer one cycle after the address is taken
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= RESP_OKAY;
		end else if (rd_fire) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rdata_next;
			s_axi_rresp <= rresp_next;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	// instruction-cycle tick for the dead-band counters
	always_ff @(posedge aclk) begin
		if (!aresetn || unit_cnt_reg == DB_UNIT_LAST) begin
			unit_cnt_reg <= 8'h00;
		end else begin
			unit_cnt_reg <= unit_cnt_reg + 8'h01;
		end
	end
	assign unit_tick = (unit_cnt_reg == DB_UNIT_LAST);

	// channel 0 wants pin a active, channel 1 wants pin b active
	assign req[0] = (mode_reg == HBP_MODE_HALF) && pwm_in;
	assign req[1] = (mode_reg == HBP_MODE_HALF) && !pwm_in;

	// dead-band: a rising request waits the count, a falling one acts at once
	generate
		for (gi = 0; gi < 2; gi++) begin : g_dead
			always_ff @(posedge aclk) begin
				if (!aresetn) begin
					req_d_reg[gi] <= 1'b0;
					act_reg[gi] <= 1'b0;
					dly_cnt_reg[gi] <= 7'h00;
				end else begin
					req_d_reg[gi] <= req[gi];
					if (!req[gi]) begin
						act_reg[gi] <= 1'b0;
						dly_cnt_reg[gi] <= 7'h00;
					end else if (!req_d_reg[gi]) begin
						dly_cnt_reg[gi] <= deadband_count;
						act_reg[gi] <= (deadband_count == 7'h00);
					end else if (dly_cnt_reg[gi] != 7'h00) begin
						if (unit_tick) begin
							dly_cnt_reg[gi] <= dly_cnt_reg[gi] - 7'h01;
							act_reg[gi] <= (dly_cnt_reg[gi] == 7'h01);
						end
					end else begin
						act_reg[gi] <= 1'b1;
					end
				end
			end
		end
	endgenerate

	// pin levels per mode, overridden by the shutdown states on the used pins
	always_comb begin
		used = 4'hf;
		out_next = 4'h0;
		case (mode_reg)
			HBP_MODE_SINGLE: begin
				used = 4'h1;
				out_next = {3'h0, pwm_in};
			end
			HBP_MODE_HALF: begin
				used = 4'h3;
				out_next = {2'h0, act_reg[1], act_reg[0]};
			end
			HBP_MODE_FWD: begin
				out_next = {pwm_in, 3'h1};
			end
			default: begin
				out_next = {1'b0, 1'b1, pwm_in, 1'b0};
			end
		endcase
		oe_next = used;
		// hold the safe states while forced or as soon as a cause is seen
		if (forced_reg || sd_cond) begin
			out_next[0] = (shutdown_state_ac == HBP_SD_HIGH);
			out_next[2] = (shutdown_state_ac == HBP_SD_HIGH);
			out_next[1] = (shutdown_state_bd == HBP_SD_HIGH);
			out_next[3] = (shutdown_state_bd == HBP_SD_HIGH);
			oe_next[0] = used[0] && !shutdown_state_ac[1];
			oe_next[2] = used[2] && !shutdown_state_ac[1];
			oe_next[1] = used[1] && !shutdown_state_bd[1];
			oe_next[3] = used[3] && !shutdown_state_bd[1];
		end
	end

	// every pin leaves through a flop so nothing glitches onto the bridge
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			{bridge_out_d, bridge_out_c, bridge_out_b, bridge_out_a} <= 4'h0;
			{bridge_oe_d, bridge_oe_c, bridge_oe_b, bridge_oe_a} <= 4'h0;
		end else begin
			{bridge_out_d, bridge_out_c, bridge_out_b, bridge_out_a} <= out_next & oe_next;
			{bridge_oe_d, bridge_oe_c, bridge_oe_b, bridge_oe_a} <= oe_next;
		end
	end

	// checks
	chk_half_complement: assert property ((mode_reg == HBP_MODE_HALF) && !forced_reg && !sd_cond &&
		deadband_count == 7'h00 && req_d_reg == req && $past(req_d_reg == req) |-> out_next[0] != out_next[1])
		else $error("half-bridge pins not complementary");
	chk_deadband_delay: assert property ($rose(req[0]) && deadband_count == 7'h03 ##1 req[0] [*3] |->
		!act_reg[0] ##1 act_reg[0])
		else $error("dead-band delay wrong length");
	chk_fall_undelayed: assert property ($fell(req[1]) |=> !act_reg[1])
		else $error("falling edge delayed");
	chk_no_source: assert property (shutdown_source_sel == 3'h0 && !shutdown_active_flag_reg |=>
		!shutdown_active_flag_reg)
		else $error("shutdown with no source selected");
	chk_sd_set: assert property (sd_cond |=> shutdown_active_flag_reg && forced_reg)
		else $error("shutdown flag not set");
	chk_flag_write_ignored: assert property (sd_cond && wr_fire && awaddr_reg == OFF_SD_CTRL |=>
		shutdown_active_flag_reg)
		else $error("flag cleared while cause active");
	chk_auto_restart: assert property (auto_restart_en && shutdown_active_flag_reg && !sd_cond |=>
		!shutdown_active_flag_reg)
		else $error("auto restart did not clear flag");
	chk_period_hold: assert property (period_start && shutdown_active_flag_reg |=> forced_reg)
		else $error("shutdown released inside period");
	chk_resume_boundary: assert property ($fell(forced_reg) |-> $past(period_start))
		else $error("resume off a period boundary");
	chk_pair_state: assert property (forced_reg && mode_reg == HBP_MODE_HALF &&
		shutdown_state_ac == HBP_SD_HIGH && shutdown_state_bd == HBP_SD_LOW |=>
		bridge_out_a && bridge_oe_a && !bridge_out_b && bridge_oe_b)
		else $error("pin pair not in shutdown state");
	chk_source_or: assert property (shutdown_source_sel[2] && src_sync_reg[2] |-> sd_cond)
		else $error("fault source not honoured");
endmodule // hbp_top

// ==== tb/hbp_leg_model.sv ====
`timescale 1ns/100ps
// one half-bridge leg: pin a gates the upper switch, pin b the lower one
module hbp_leg_model (
	// gate drive from the block
	input wire logic hi_in,
	input wire logic hi_oe,
	input wire logic lo_in,
	input wire logic lo_oe,
	// switch states
	output logic hi_on,
	output logic lo_on,
	output logic shoot
);
	// gate pull-downs keep an undriven switch off, so a floating pin never turns it on
	assign hi_on = hi_oe & hi_in;
	assign lo_on = lo_oe & lo_in;
	// both switches on shorts the bridge supply
	assign shoot = hi_on & lo_on;
endmodule // hbp_leg_model

// ==== tb/hbp_top_bench.sv ====
`timescale 1ns/100ps
module hbp_top_bench;
	import hbp_pkg::*;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0, rdata, rd;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid, irq;
	logic [1:0] bresp, rresp;
	logic pwm_in = 1'b0, period_start = 1'b0, cmp1_in = 1'b0, cmp2_in = 1'b0, fault_in_n = 1'b1;
	logic a, oe_a, b, oe_b, c, oe_c, d, oe_d, hi_on, lo_on, shoot;
	int err_total = 0, checks_done = 0, cyc = 0;
	localparam logic [7:0] HALF = 8'hf0;
	localparam logic [7:0] FULL = 8'hff;

	always #2 aclk = ~aclk;

	// prot and strobe are tied: the block ignores prot and uses only the low byte lane
	hbp_top i_hbp_top (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'h1),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .pwm_in(pwm_in), .period_start(period_start), .cmp1_in(cmp1_in),
		.cmp2_in(cmp2_in), .fault_in_n(fault_in_n), .bridge_out_a(a), .bridge_oe_a(oe_a),
		.bridge_out_b(b), .bridge_oe_b(oe_b), .bridge_out_c(c), .bridge_oe_c(oe_c),
		.bridge_out_d(d), .bridge_oe_d(oe_d), .irq(irq));

	hbp_leg_model i_hbp_leg_model (.hi_in(a), .hi_oe(oe_a), .lo_in(b), .lo_oe(oe_b),
		.hi_on(hi_on), .lo_on(lo_on), .shoot(shoot));

	task automatic tally_and_finish();
		if (err_total == 0 && checks_done > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	// a hung handshake must still reach the verdict
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			err_total++;
			tally_and_finish();
		end
	end

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks_done++;
		if (got !== exp) begin
			err_total++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask

	// handshakes are judged on values settled before the edge, so no race with the design
	task automatic axi_wr(input logic [7:0] ad, input logic [7:0] dt, input logic [1:0] exp_r);
		logic aw_hs, w_hs, b_hs;
		logic [1:0] r;
		int n;
		@(posedge aclk);
		awaddr <= ad;
		wdata <= {24'h0, dt};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		n = 0;
		b_hs = 1'b0;
		while (!b_hs && n < 50) begin
			#1;
			aw_hs = awvalid & awready;
			w_hs = wvalid & wready;
			b_hs = bvalid & bready;
			r = bresp;
			@(posedge aclk);
			if (aw_hs) awvalid <= 1'b0;
			if (w_hs) wvalid <= 1'b0;
			n++;
		end
		bready <= 1'b0;
		chk("write handshake", 1, {31'h0, b_hs});
		chk("write response", {30'h0, exp_r}, {30'h0, r});
	endtask

	task automatic axi_rd(input logic [7:0] ad, output logic [31:0] dt, output logic [1:0] r);
		logic ar_hs, r_hs;
		int n;
		@(posedge aclk);
		araddr <= ad;
		arvalid <= 1'b1;
		rready <= 1'b1;
		n = 0;
		r_hs = 1'b0;
		while (!r_hs && n < 50) begin
			#1;
			ar_hs = arvalid & arready;
			r_hs = rvalid & rready;
			dt = rdata;
			r = rresp;
			@(posedge aclk);
			if (ar_hs) arvalid <= 1'b0;
			n++;
		end
		rready <= 1'b0;
		chk("read handshake", 1, {31'h0, r_hs});
	endtask

	task automatic rd_chk(input string what, input logic [7:0] ad, input logic [31:0] exp);
		logic [31:0] v;
		logic [1:0] r;
		axi_rd(ad, v, r);
		chk("read response", {30'h0, RESP_OKAY}, {30'h0, r});
		chk(what, exp, v);
	endtask

	// pins packed as a, oe_a, b, oe_b, c, oe_c, d, oe_d; waits at most k cycles for a match
	task automatic wait_pins(input logic [7:0] exp, input logic [7:0] msk, input int k);
		int n;
		n = 0;
		#1;
		while ((({a, oe_a, b, oe_b, c, oe_c, d, oe_d} & msk) !== exp) && n < k) begin
			@(posedge aclk);
			#1;
			n++;
		end
		chk("bridge pins", {24'h0, exp}, {24'h0, {a, oe_a, b, oe_b, c, oe_c, d, oe_d} & msk});
	endtask

	task automatic set_src(input int k, input logic on);
		@(posedge aclk);
		case (k)
			0: cmp1_in <= on;
			1: cmp2_in <= on;
			default: fault_in_n <= ~on;
		endcase
	endtask

	task automatic pulse_ps();
		@(posedge aclk);
		period_start <= 1'b1;
		@(posedge aclk);
		period_start <= 1'b0;
	endtask

	task automatic t_regs();
		logic [1:0] r;
		rd_chk("deadband reset", OFF_DB_CTRL, 32'h00);
		rd_chk("shutdown reset", OFF_SD_CTRL, 32'h00);
		axi_wr(OFF_DB_CTRL, 8'hff, RESP_OKAY);
		rd_chk("deadband readback", OFF_DB_CTRL, 32'hff);
		axi_wr(8'h18, 8'h55, RESP_SLVERR);
		axi_rd(8'h18, rd, r);
		chk("unmapped read", {30'h0, RESP_SLVERR}, {30'h0, r});
	endtask

	// pwm high for w cycles under dead-band n; counts are exact because each cycle is sampled once
	task automatic t_deadband(input int w, input int n);
		logic [31:0] a_hi, b_lo, both;
		axi_wr(OFF_DB_CTRL, 8'(n), RESP_OKAY);
		a_hi = 0;
		b_lo = 0;
		both = 0;
		for (int i = 0; i < 64; i++) begin
			@(posedge aclk);
			pwm_in <= (i < w);
			#1;
			a_hi = a_hi + {31'h0, hi_on};
			b_lo = b_lo + {31'h0, ~lo_on};
			both = both + {31'h0, shoot};
		end
		chk("upper on cycles", (w > n) ? w - n : 0, a_hi);
		chk("lower off cycles", w + n, b_lo);
		chk("shoot through", 0, both);
	endtask

	task automatic t_sd_manual();
		axi_wr(OFF_DB_CTRL, 8'h00, RESP_OKAY);
		axi_wr(OFF_SD_CTRL, 8'h14, RESP_OKAY);
		axi_wr(OFF_INT_MASK, 8'h01, RESP_OKAY);
		set_src(0, 1'b1);
		wait_pins(8'hd0, HALF, 4);
		rd_chk("flag set", OFF_SD_CTRL, 32'h94);
		rd_chk("source status", OFF_SRC_STAT, 32'h19);
		chk("irq raised", 1, {31'h0, irq});
		axi_wr(OFF_SD_CTRL, 8'h14, RESP_OKAY);
		rd_chk("flag write ignored", OFF_SD_CTRL, 32'h94);
		set_src(0, 1'b0);
		repeat (6) @(posedge aclk);
		rd_chk("flag kept", OFF_SD_CTRL, 32'h94);
		wait_pins(8'hd0, HALF, 0);
		axi_wr(OFF_SD_CTRL, 8'h14, RESP_OKAY);
		rd_chk("flag cleared", OFF_SD_CTRL, 32'h14);
		wait_pins(8'hd0, HALF, 0);
		pulse_ps();
		wait_pins(8'h70, HALF, 4);
		rd_chk("int status", OFF_INT_STAT, 32'h03);
		rd_chk("int status clear", OFF_INT_STAT, 32'h00);
		chk("irq cleared", 0, {31'h0, irq});
	endtask

	task automatic t_sd_auto();
		axi_wr(OFF_INT_MASK, 8'h00, RESP_OKAY);
		axi_wr(OFF_DB_CTRL, 8'h80, RESP_OKAY);
		axi_wr(OFF_SD_CTRL, 8'h4a, RESP_OKAY);
		set_src(2, 1'b1);
		wait_pins(8'h00, HALF, 4);
		chk("irq masked", 0, {31'h0, irq});
		pulse_ps();
		repeat (3) @(posedge aclk);
		wait_pins(8'h00, HALF, 0);
		set_src(2, 1'b0);
		repeat (6) @(posedge aclk);
		rd_chk("flag auto clear", OFF_SD_CTRL, 32'h4a);
		wait_pins(8'h00, HALF, 0);
		pulse_ps();
		wait_pins(8'h70, HALF, 4);
	endtask

	task automatic t_sd_sources();
		int src;
		axi_wr(OFF_SD_CTRL, 8'h00, RESP_OKAY);
		for (int k = 0; k < 3; k++) set_src(k, 1'b1);
		repeat (8) @(posedge aclk);
		wait_pins(8'h70, HALF, 0);
		rd_chk("no flag", OFF_SD_CTRL, 32'h00);
		for (int k = 0; k < 3; k++) set_src(k, 1'b0);
		// last pass selects all three but fires only one of them
		for (int k = 0; k < 4; k++) begin
			src = (k == 3) ? 1 : k;
			axi_wr(OFF_SD_CTRL, (k == 3) ? 8'h74 : 8'(8'h04 | (8'h10 << k)), RESP_OKAY);
			set_src(src, 1'b1);
			wait_pins(8'hd0, HALF, 4);
			set_src(src, 1'b0);
			repeat (6) @(posedge aclk);
			pulse_ps();
			wait_pins(8'h70, HALF, 4);
		end
	endtask

	// one mode: idle pins with pwm low, forced pins under cmp1, then release at a period start
	task automatic sd_mode(input hbp_mode_t m, input logic [7:0] norm, input logic [7:0] shut);
		axi_wr(OFF_MODE, {6'h0, m}, RESP_OKAY);
		wait_pins(norm, FULL, 4);
		set_src(0, 1'b1);
		wait_pins(shut, FULL, 4);
		set_src(0, 1'b0);
		repeat (6) @(posedge aclk);
		pulse_ps();
		wait_pins(norm, FULL, 4);
	endtask

	task automatic t_sd_modes();
		axi_wr(OFF_SD_CTRL, 8'h14, RESP_OKAY);
		sd_mode(HBP_MODE_FWD, 8'hd5, 8'hdd);
		sd_mode(HBP_MODE_REV, 8'h5d, 8'hdd);
		sd_mode(HBP_MODE_SINGLE, 8'h40, 8'hc0);
		axi_wr(OFF_MODE, {6'h0, HBP_MODE_HALF}, RESP_OKAY);
		wait_pins(8'h70, HALF, 4);
	endtask

	initial begin
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		t_regs();
		t_deadband(10, 0);
		t_deadband(10, 3);
		t_deadband(5, 5);
		t_deadband(4, 9);
		t_deadband(6, 40);
		t_sd_manual();
		t_sd_auto();
		t_sd_sources();
		t_sd_modes();
		tally_and_finish();
	end
endmodule // hbp_top_bench
